/* File: osc_edge_sync.sv */
// three-stage synchroniser for an oscillator pin with a rising-edge pulse out.
// assumes the oscillator runs well below half of ref_clk.
`timescale 1ns/100ps
module osc_edge_sync
  import touch_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin side
  input wire logic pin,
  output logic rise
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic level;
    logic rise;
  } sync_t;
  sync_t r;
  sync_t next_r;
  // a change counts only once stages two and three agree
  always_comb begin
    next_r = r;
    next_r.stage = {r.stage[1:0], pin};
    next_r.rise = 1'b0;
    if (r.stage[1] == r.stage[2]) begin
      next_r.level = r.stage[2];
      next_r.rise = r.stage[2] && !r.level;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign rise = r.rise;
endmodule

/* File: osc_model.sv */
// pad-side model: reference and touch oscillators for both scan units.
// assumes the block powers an oscillator through its enable; half periods in clocks.
`timescale 1ns/100ps
module osc_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // oscillator speed and power
  input wire logic [1:0] enable,
  input wire logic [7:0] ref_half,
  input wire logic [1:0][7:0] touch_half,
  // oscillator pins
  output logic [1:0] ref_osc,
  output logic [1:0] touch_osc
);
  // ----------------------------------------
  // oscillators
  // ----------------------------------------
  logic [1:0][7:0] rcnt;
  logic [1:0][7:0] tcnt;
  // a powered-down unit leaves its pad driven low and still, so no stray edges reach it
  always @(posedge ref_clk) begin
    for (int u = 0; u < 2; u++) begin
      if (rst || !enable[u]) begin
        rcnt[u] <= 8'h00;
        tcnt[u] <= 8'h00;
        ref_osc[u] <= 1'b0;
        touch_osc[u] <= 1'b0;
      end else begin
        rcnt[u] <= (rcnt[u] >= ref_half - 8'h01) ? 8'h00 : rcnt[u] + 8'h01;
        tcnt[u] <= (tcnt[u] >= touch_half[u] - 8'h01) ? 8'h00 : tcnt[u] + 8'h01;
        if (rcnt[u] >= ref_half - 8'h01) ref_osc[u] <= ~ref_osc[u];
        if (tcnt[u] >= touch_half[u] - 8'h01) touch_osc[u] <= ~touch_osc[u];
      end
    end
  end
endmodule

/* File: scan_if.sv */
// control/result carrier between the register block and one scan unit.
// assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface scan_if;
  import touch_pkg::*;
  logic start;
  logic abort;
  logic [CNT_W-1:0] target;
  logic busy;
  logic done;
  logic [CNT_W-1:0] result;
  modport ctrl (output start, output abort, output target, input busy, input done,
    input result);
  modport unit (input start, input abort, input target, output busy, output done,
    output result);
endinterface

/* File: scan_unit.sv */
// one touch scan unit: reference window counter, data counter, result holder.
// assumes raw reference and touch oscillator pins; the unit syncs them itself.
`timescale 1ns/100ps
module scan_unit
  import touch_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // oscillators
  input wire logic ref_osc,
  input wire logic touch_osc,
  // control side
  scan_if.unit port
);
  typedef struct packed {
    scan_state_t state;
    logic [CNT_W-1:0] ref_cnt;
    logic [CNT_W-1:0] data_cnt;
    logic [CNT_W-1:0] result;
  } unit_t;
  unit_t r;
  unit_t next_r;
  logic ref_rise;
  logic touch_rise;
  osc_edge_sync ref_sync (.ref_clk(ref_clk), .rst(rst), .pin(ref_osc), .rise(ref_rise));
  osc_edge_sync touch_sync (.ref_clk(ref_clk), .rst(rst), .pin(touch_osc),
    .rise(touch_rise));
  always_comb begin
    next_r = r;
    case (r.state)
      SCAN_IDLE: if (port.start) begin
        next_r.state = SCAN_RUN;
        next_r.ref_cnt = '0;
        next_r.data_cnt = '0;
      end
      SCAN_RUN: begin
        if (port.abort) begin
          next_r.state = SCAN_IDLE;
        end else if (r.ref_cnt == port.target) begin
          next_r.state = SCAN_STORE;
        end else begin
          if (ref_rise) next_r.ref_cnt = r.ref_cnt + 1'b1;
          // saturate rather than wrap so a fast pad never reads as touched
          if (touch_rise && !(&r.data_cnt)) next_r.data_cnt = r.data_cnt + 1'b1;
        end
      end
      SCAN_STORE: begin
        next_r.result = r.data_cnt;
        next_r.state = SCAN_IDLE;
      end
      default: next_r.state = SCAN_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign port.busy = r.state != SCAN_IDLE;
  assign port.done = r.state == SCAN_STORE;
  assign port.result = r.result;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  window_end_a: assert property ((r.state == SCAN_RUN) && !port.abort && (r.ref_cnt == port.target)
    |=> port.done) else $error("window end missed");
  result_hold_a: assert property (port.done |=> port.result == $past(r.data_cnt))
    else $error("result not stored");
  fresh_count_a: assert property (port.start && !port.busy |=> r.data_cnt == 0 && r.ref_cnt == 0)
    else $error("counters not cleared");
endmodule

/* File: testbench.sv */
// self-checking bench for the two-unit touch scanner.
// assumes osc_model stands in for the pads and an avalon-mm master drives the registers.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
  import touch_pkg::*;
  typedef struct packed {logic w; logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, internal_ref_connect, touch_irq;
  logic [1:0] ref_osc, touch_osc, unit_osc_enable;
  logic [6:0] pad_connect;
  logic [CAP_W-1:0] unit_a_refosc_cap_select, unit_b_refosc_cap_select, internal_ref_cap_select;
  logic [7:0] ref_half = 8'h04;
  logic [1:0][7:0] touch_half = {8'h02, 8'h02};
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [13:0] res1, res2;
  row_t rows [$] = '{{1'b0, 8'had, 8'h00, 8'hcc}, {1'b0, 8'hb3, 8'h00, 8'h00},
    {1'b0, 8'hb4, 8'h00, 8'hff}, {1'b0, 8'hb5, 8'h00, 8'h00}, {1'b0, 8'hc1, 8'h00, 8'hff},
    {1'b0, 8'hc2, 8'h00, 8'h00}, {1'b0, 8'h95, 8'h00, 8'h00}, {1'b0, 8'h85, 8'h00, 8'h00},
    {1'b0, 8'h84, 8'h00, 8'h00}, {1'b0, 8'ha9, 8'h00, 8'h00}, {1'b0, 8'h20, 8'h00, 8'h00},
    {1'b1, 8'hb3, 8'h21, 8'h21}, {1'b1, 8'hb5, 8'hff, 8'h3f}, {1'b1, 8'hc2, 8'h15, 8'h15},
    {1'b1, 8'hb1, 8'h7f, 8'h7f}, {1'b1, 8'hc3, 8'h11, 8'h11}, {1'b1, 8'hc4, 8'h22, 8'h22},
    {1'b1, 8'h84, 8'h03, 8'h03}, {1'b1, 8'ha9, 8'h08, 8'h08}, {1'b1, 8'h20, 8'h5a, 8'h00}};

  touch_scan touch_scan_i (.ref_clk, .rst, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .ref_osc, .touch_osc, .pad_connect, .internal_ref_connect,
    .unit_osc_enable, .unit_a_refosc_cap_select, .unit_b_refosc_cap_select,
    .internal_ref_cap_select, .touch_irq);
  osc_model osc_model_i (.ref_clk, .rst, .enable(unit_osc_enable), .ref_half, .touch_half,
    .ref_osc, .touch_osc);

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    do begin @(posedge ref_clk); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin error_cnt++; $display("BAD waitrequest exp 0 got 1"); end
    d = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00);
    `CHK($sformatf("reg %h", idx), ex, d)
  endtask
  task automatic wait_done(input int b);
    int n;
    n = 0;
    do begin bus(1'b0, REG_CONTROL, 8'h00); n++; end while (d[b] !== 1'b1 && n < 3000);
    `CHK("done bit", 1'b1, d[b])
  endtask
  task automatic get_res(input logic [7:0] lo, input logic [7:0] hi, output logic [13:0] r);
    bus(1'b0, lo, 8'h00);
    r[7:0] = d;
    bus(1'b0, hi, 8'h00);
    r[13:8] = d[5:0];
    `CHK("result top bits", 2'b00, d[7:6])
  endtask
  task automatic conclude;
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].idx, rows[i].wd);
      chk(rows[i].idx, rows[i].ex);
    end
    `CHK("cap a", 7'h7f, unit_a_refosc_cap_select)
    `CHK("cap int", 7'h11, internal_ref_cap_select)
    `CHK("cap b", 7'h22, unit_b_refosc_cap_select)
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, REG_CHSEL, {2'b00, s[1:0], 2'b00, s[1:0]});
      bus(1'b1, REG_CONTROL, 8'h4c);
      #1 `CHK("pad a", 7'h01 << s, pad_connect)
      bus(1'b1, REG_CONTROL, 8'hc4);
      #1 `CHK("pad b", (s < 3) ? 7'h10 << s : 7'h00, pad_connect)
      `CHK("ref cap link", s == 3, internal_ref_connect)
    end
    bus(1'b1, REG_CONTROL, 8'hcc);
    #1 `CHK("pad off", 7'h00, pad_connect)
    `CHK("osc off", 2'b00, unit_osc_enable)
    chk(REG_MAIN_FLAGS, 8'h20);
    bus(1'b1, REG_MAIN_FLAGS, 8'hdf);
    chk(REG_MAIN_FLAGS, 8'h00);
    bus(1'b1, REG_CHSEL, 8'h03);
    bus(1'b1, REG_A_TGT_HI, 8'h00);
    bus(1'b1, REG_A_TGT_LO, 8'h10);
    bus(1'b1, REG_B_TGT_HI, 8'h00);
    bus(1'b1, REG_B_TGT_LO, 8'h10);
    bus(1'b1, REG_IRQ_ENABLE_B, 8'h01);
    bus(1'b1, REG_CONTROL, 8'h6c);
    chk(REG_CONTROL, 8'h2c);
    wait_done(CTL_A_EOC);
    chk(REG_CONTROL, 8'h4c);
    get_res(REG_A_RES_LO, REG_A_RES_HI, res1);
    // 16 reference periods of 8 clocks, touch period 4: 32 edges, less one for start phase
    `CHK("result a in window", 1'b1, res1 >= 30 && res1 <= 33)
    chk(REG_IRQ_FLAGS_B, 8'h01);
    chk(REG_MAIN_FLAGS, 8'h20);
    `CHK("irq on", 1'b1, touch_irq)
    bus(1'b1, REG_MAIN_ENABLE_A, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 `CHK("irq gated", 1'b0, touch_irq)
    bus(1'b1, REG_MAIN_ENABLE_A, 8'h08);
    bus(1'b1, REG_A_RES_LO, ~res1[7:0]);
    chk(REG_A_RES_LO, res1[7:0]);
    bus(1'b1, REG_IRQ_FLAGS_B, 8'hfe);
    chk(REG_IRQ_FLAGS_B, 8'h00);
    #1 `CHK("irq off", 1'b0, touch_irq)
    chk(REG_MAIN_FLAGS, 8'h20);
    bus(1'b1, REG_IRQ_ENABLE_B, 8'h03);
    bus(1'b1, REG_CONTROL, 8'h46);
    chk(REG_MAIN_FLAGS, 8'h00);
    wait_done(CTL_B_EOC);
    chk(REG_IRQ_FLAGS_B, 8'h02);
    get_res(REG_B_RES_LO, REG_B_RES_HI, res2);
    `CHK("result b in window", 1'b1, res2 >= 30 && res2 <= 33)
    touch_half <= {8'h02, 8'h04};
    bus(1'b1, REG_CONTROL, 8'h64);
    wait_done(CTL_A_EOC);
    get_res(REG_A_RES_LO, REG_A_RES_HI, res2);
    // reference already running, so the window is 15 to 16 periods long
    `CHK("slower touch", 1'b1, res2 < res1 && res2 >= 14 && res2 <= 17)
    chk(REG_IRQ_FLAGS_B, 8'h03);
    bus(1'b1, REG_MAIN_FLAGS, 8'hdf);
    chk(REG_IRQ_FLAGS_B, 8'h00);
    bus(1'b1, REG_A_TGT_HI, 8'h01);
    bus(1'b1, REG_CONTROL, 8'h64);
    repeat (20) @(posedge ref_clk);
    bus(1'b1, REG_CONTROL, 8'he4);
    chk(REG_CONTROL, 8'hc4);
    chk(REG_IRQ_FLAGS_B, 8'h00);
    chk(REG_A_RES_LO, res2[7:0]);
    bus(1'b1, REG_A_TGT_HI, 8'h00);
    bus(1'b1, REG_A_TGT_LO, 8'h00);
    bus(1'b1, REG_CONTROL, 8'h64);
    wait_done(CTL_A_EOC);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    chk(REG_CONTROL, 8'hcc);
    chk(REG_A_TGT_LO, 8'hff);
    conclude();
  end
endmodule

/* File: touch_pkg.sv */
// touch scan constants: register indices, field positions, reset values, states.
// assumes an avalon-mm slave with byte address = 4 * register index.
package touch_pkg;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned CAP_W = 7;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned SYNC_STAGES = 3;
  // register indices
  localparam logic [7:0] REG_IRQ_ENABLE_B = 8'h84;
  localparam logic [7:0] REG_IRQ_FLAGS_B = 8'h85;
  localparam logic [7:0] REG_B_RES_LO = 8'h8e;
  localparam logic [7:0] REG_B_RES_HI = 8'h8f;
  localparam logic [7:0] REG_MAIN_FLAGS = 8'h95;
  localparam logic [7:0] REG_MAIN_ENABLE_A = 8'ha9;
  localparam logic [7:0] REG_A_RES_LO = 8'hac;
  localparam logic [7:0] REG_CONTROL = 8'had;
  localparam logic [7:0] REG_A_REFC = 8'hb1;
  localparam logic [7:0] REG_A_RES_HI = 8'hb2;
  localparam logic [7:0] REG_CHSEL = 8'hb3;
  localparam logic [7:0] REG_A_TGT_LO = 8'hb4;
  localparam logic [7:0] REG_A_TGT_HI = 8'hb5;
  localparam logic [7:0] REG_B_TGT_LO = 8'hc1;
  localparam logic [7:0] REG_B_TGT_HI = 8'hc2;
  localparam logic [7:0] REG_INT_CAP = 8'hc3;
  localparam logic [7:0] REG_B_REFC = 8'hc4;
  // field positions
  localparam int BIT_A_IRQ = 0;
  localparam int BIT_B_IRQ = 1;
  localparam int BIT_COMMON_IRQ = 5;
  localparam int BIT_SHARED_EN = 3;
  localparam int CTL_A_PD = 7;
  localparam int CTL_A_EOC = 6;
  localparam int CTL_A_SOC = 5;
  localparam int CTL_B_PD = 3;
  localparam int CTL_B_EOC = 2;
  localparam int CTL_B_SOC = 1;
  localparam int CHSEL_A_LSB = 0;
  localparam int CHSEL_B_LSB = 4;
  localparam int CH_PER_UNIT = 4;
  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'hcc;
  localparam logic [7:0] TGT_LO_RESET = 8'hff;
  localparam logic [5:0] TGT_HI_RESET = 6'h00;
  localparam logic [1:0] CHSEL_RESET = 2'h0;
  localparam logic [CAP_W-1:0] CAP_RESET = 7'h40;
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01,
    SCAN_STORE = 2'b11
  } scan_state_t;
endpackage

/* File: touch_scan.sv */
// register block and pad routing for the two-unit touch scanner.
// assumes an avalon-mm master with byte addresses and raw oscillator pins.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - eight channels; unit a scans 0..3, unit b scans 4..7.
// - reference counter ends the window after the programmed reference count.
// - data counter counts touch cycles; 14-bit count kept as the result.
// - start clears itself when conversion done rises.
// - conversion done reads 0 while converting, 1 once the result is stored.
// - common flag sets on the first power-up; software then clears it.
// - powered unit connects its selected channel; power-down disconnects it.
// - unit a flag sets at scan end; writing fe clears it.
// - unit b flag sets at scan end; writing fd clears it.
// - common flag sets at any scan end; cleared by writing df or start.
// - clearing the common flag by writing df also clears both unit flags; a start does not.
// - separate unit a and unit b interrupt enables.
// - one shared enable gates the combined interrupt.
// - unit a power-down, done, start at bits 7, 6, 5.
// - unit b power-down, done, start at bits 3, 2, 1.
// - unit b select at bits 5:4 picks channel 4..7, 7 internal.
// - unit a select is bits 1:0 of the select register.
// - unit a select 00..11 picks channel 0..3.
// - channel 7 is an internal capacitor with its own value field.
// - each unit has a 7-bit reference oscillator capacitor field.
// - results are read-only: low byte plus six high bits.
// - reference count: low byte resets to ff, high six bits to 0.
module touch_scan
  import touch_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // oscillators, index 0 is unit a
  input wire logic [1:0] ref_osc,
  input wire logic [1:0] touch_osc,
  // analog side
  output logic [6:0] pad_connect,
  output logic internal_ref_connect,
  output logic [1:0] unit_osc_enable,
  output logic [CAP_W-1:0] unit_a_refosc_cap_select,
  output logic [CAP_W-1:0] unit_b_refosc_cap_select,
  output logic [CAP_W-1:0] internal_ref_cap_select,
  // interrupt request towards the core
  output logic touch_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] power_down;
    logic [1:0] conversion_done;
    logic [1:0] start_conversion;
    logic [1:0] start;
    logic [1:0] irq_enable;
    logic [1:0] irq_flag;
    logic shared_enable;
    logic common_flag;
    logic ever_on;
    logic [1:0][1:0] channel_select;
    logic [1:0][CNT_W-1:0] target;
    logic [1:0][CAP_W-1:0] refosc_cap;
    logic [CAP_W-1:0] internal_cap;
    logic irq;
  } regs_t;
  regs_t r;
  regs_t next_r;
  scan_if su[2] ();
  logic [7:0] idx;
  logic [7:0] wd;
  logic do_wr;
  logic [7:0] rd_byte;
  logic [1:0] done;
  logic [1:0] busy;
  logic [7:0] connect;

  function automatic int pd_pos(input int u);
    return (u == 0) ? CTL_A_PD : CTL_B_PD;
  endfunction
  function automatic int soc_pos(input int u);
    return (u == 0) ? CTL_A_SOC : CTL_B_SOC;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: request seen, answer registered, then released
  assign idx = address[ADDR_W-1:2];
  assign wd = writedata[7:0];
  assign waitrequest = (read || write) && !r.ack;
  assign do_wr = write && r.ack && byteenable[0];
  assign readdata = r.rdata;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      REG_IRQ_ENABLE_B: rd_byte = {6'h00, r.irq_enable};
      REG_IRQ_FLAGS_B: rd_byte = {6'h00, r.irq_flag};
      REG_B_RES_LO: rd_byte = su[1].result[7:0];
      REG_B_RES_HI: rd_byte = {2'h0, su[1].result[CNT_W-1:8]};
      REG_MAIN_FLAGS: rd_byte[BIT_COMMON_IRQ] = r.common_flag;
      REG_MAIN_ENABLE_A: rd_byte[BIT_SHARED_EN] = r.shared_enable;
      REG_A_RES_LO: rd_byte = su[0].result[7:0];
      REG_A_RES_HI: rd_byte = {2'h0, su[0].result[CNT_W-1:8]};
      REG_CONTROL: begin
        rd_byte[CTL_A_PD] = r.power_down[0];
        rd_byte[CTL_A_EOC] = r.conversion_done[0];
        rd_byte[CTL_A_SOC] = r.start_conversion[0];
        rd_byte[CTL_B_PD] = r.power_down[1];
        rd_byte[CTL_B_EOC] = r.conversion_done[1];
        rd_byte[CTL_B_SOC] = r.start_conversion[1];
      end
      REG_A_REFC: rd_byte = {1'b0, r.refosc_cap[0]};
      REG_CHSEL: begin
        rd_byte[CHSEL_A_LSB +: 2] = r.channel_select[0];
        rd_byte[CHSEL_B_LSB +: 2] = r.channel_select[1];
      end
      REG_A_TGT_LO: rd_byte = r.target[0][7:0];
      REG_A_TGT_HI: rd_byte = {2'h0, r.target[0][CNT_W-1:8]};
      REG_B_TGT_LO: rd_byte = r.target[1][7:0];
      REG_B_TGT_HI: rd_byte = {2'h0, r.target[1][CNT_W-1:8]};
      REG_INT_CAP: rd_byte = {1'b0, r.internal_cap};
      REG_B_REFC: rd_byte = {1'b0, r.refosc_cap[1]};
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // register and flag update
  // ----------------------------------------------------------------
  // clears are applied first and hardware sets last, so a set in the
  // same cycle as a software clear is never lost
  always_comb begin
    next_r = r;
    next_r.start = 2'b00;
    next_r.ack = 1'b0;
    if ((read || write) && !r.ack) begin
      next_r.ack = 1'b1;
      if (read) next_r.rdata = {24'h000000, rd_byte};
    end
    if (do_wr) begin
      case (idx)
        REG_IRQ_ENABLE_B: next_r.irq_enable = wd[1:0];
        // writing a 0 to a flag clears it, a 1 leaves it
        REG_IRQ_FLAGS_B: begin
          next_r.irq_flag[0] = r.irq_flag[0] && wd[BIT_A_IRQ];
          next_r.irq_flag[1] = r.irq_flag[1] && wd[BIT_B_IRQ];
        end
        REG_MAIN_FLAGS: if (!wd[BIT_COMMON_IRQ]) begin
          next_r.common_flag = 1'b0;
          next_r.irq_flag = 2'b00;
        end
        REG_MAIN_ENABLE_A: next_r.shared_enable = wd[BIT_SHARED_EN];
        REG_CONTROL: begin
          for (int u = 0; u < 2; u++) begin
            next_r.power_down[u] = wd[pd_pos(u)];
            // a start is only taken by a powered, idle unit
            if (wd[soc_pos(u)] && !wd[pd_pos(u)] && !r.start_conversion[u]) begin
              next_r.start_conversion[u] = 1'b1;
              next_r.conversion_done[u] = 1'b0;
              next_r.start[u] = 1'b1;
              next_r.common_flag = 1'b0;
            end
          end
        end
        REG_A_REFC: next_r.refosc_cap[0] = wd[CAP_W-1:0];
        REG_CHSEL: begin
          next_r.channel_select[0] = wd[CHSEL_A_LSB +: 2];
          next_r.channel_select[1] = wd[CHSEL_B_LSB +: 2];
        end
        REG_A_TGT_LO: next_r.target[0][7:0] = wd;
        REG_A_TGT_HI: next_r.target[0][CNT_W-1:8] = wd[5:0];
        REG_B_TGT_LO: next_r.target[1][7:0] = wd;
        REG_B_TGT_HI: next_r.target[1][CNT_W-1:8] = wd[5:0];
        REG_INT_CAP: next_r.internal_cap = wd[CAP_W-1:0];
        REG_B_REFC: next_r.refosc_cap[1] = wd[CAP_W-1:0];
        default: ;
      endcase
    end
    for (int u = 0; u < 2; u++) begin
      // powering down mid-scan abandons it; the old result stays
      if (r.power_down[u] && r.start_conversion[u] && !done[u]) begin
        next_r.start_conversion[u] = 1'b0;
        next_r.conversion_done[u] = 1'b1;
      end
      if (done[u]) begin
        next_r.conversion_done[u] = 1'b1;
        next_r.start_conversion[u] = 1'b0;
        next_r.irq_flag[u] = 1'b1;
        next_r.common_flag = 1'b1;
      end
      if (r.power_down[u] && !next_r.power_down[u] && !r.ever_on) begin
        next_r.ever_on = 1'b1;
        next_r.common_flag = 1'b1;
      end
    end
    next_r.irq = next_r.shared_enable && |(next_r.irq_enable & next_r.irq_flag);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      r.power_down <= {CONTROL_RESET[CTL_B_PD], CONTROL_RESET[CTL_A_PD]};
      r.conversion_done <= {CONTROL_RESET[CTL_B_EOC], CONTROL_RESET[CTL_A_EOC]};
      r.start_conversion <= {CONTROL_RESET[CTL_B_SOC], CONTROL_RESET[CTL_A_SOC]};
      r.channel_select <= {CHSEL_RESET, CHSEL_RESET};
      r.target <= {{TGT_HI_RESET, TGT_LO_RESET}, {TGT_HI_RESET, TGT_LO_RESET}};
      r.refosc_cap <= {CAP_RESET, CAP_RESET};
      r.internal_cap <= CAP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // scan units and pad routing
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_unit
    assign su[g].start = r.start[g];
    assign su[g].abort = r.power_down[g];
    assign su[g].target = r.target[g];
    assign done[g] = su[g].done;
    assign busy[g] = su[g].busy;
    scan_unit unit (
      .ref_clk(ref_clk),
      .rst(rst),
      .ref_osc(ref_osc[g]),
      .touch_osc(touch_osc[g]),
      .port(su[g])
    );
  end

  // channel ch belongs to unit ch/4, picked by select value ch%4
  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    assign connect[ch] = !r.power_down[ch / CH_PER_UNIT]
      && (r.channel_select[ch / CH_PER_UNIT] == 2'(ch % CH_PER_UNIT));
  end

  assign pad_connect = connect[6:0];
  assign internal_ref_connect = connect[7];
  assign unit_osc_enable = ~r.power_down;
  assign unit_a_refosc_cap_select = r.refosc_cap[0];
  assign unit_b_refosc_cap_select = r.refosc_cap[1];
  assign internal_ref_cap_select = r.internal_cap;
  assign touch_irq = r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  bus_one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  soc_autoclear_a: assert property ($rose(r.conversion_done[0]) |-> !r.start_conversion[0])
    else $error("start not cleared at done");
  eoc_busy_a: assert property (busy[1] |-> !r.conversion_done[1])
    else $error("done high while converting");
  flag_a_set_a: assert property (done[0] |=> r.irq_flag[0] && r.common_flag)
    else $error("unit a flag not set");
  flag_b_set_a: assert property (done[1] |=> r.irq_flag[1] && r.common_flag)
    else $error("unit b flag not set");
  common_clear_a: assert property (do_wr && idx == REG_MAIN_FLAGS && !wd[BIT_COMMON_IRQ]
    && done == 2'b00 && !(r.power_down != 2'b00 && !r.ever_on) |=> !r.common_flag)
    else $error("common flag not cleared");
  cascade_clear_a: assert property (do_wr && idx == REG_MAIN_FLAGS && !wd[BIT_COMMON_IRQ]
    && done == 2'b00 |=> r.irq_flag == 2'b00)
    else $error("unit flags not cleared");
  first_on_a: assert property ($rose(r.ever_on) |-> r.common_flag)
    else $error("first power-up flag missing");
  pd_disconnect_a: assert property (r.power_down[0] |-> connect[3:0] == 4'h0)
    else $error("powered-down unit connected");
  chsel_b_a: assert property (!r.power_down[1] |-> connect[7:4] == (4'h1 << r.channel_select[1]))
    else $error("unit b routed wrong");
  irq_gate_a: assert property (!r.shared_enable |-> !touch_irq)
    else $error("irq passed while disabled");
  scan_a_c: cover property (r.start[0] ##[1:1000] done[0]);
  scan_b_c: cover property (r.start[1] ##[1:1000] done[1]);
  abort_c: cover property (busy[0] && r.power_down[0]);
  irq_c: cover property ($rose(touch_irq));
endmodule
